// ==== src/rcbr_pkg.sv ====
// Shared constants for the range check and bias recalibration register bank
package rcbr_pkg;

	// ==========================================================
	// Register indices on the serial link
	localparam logic [15:0] ADDR_GLASS_RATE_HI = 16'h0026;
	localparam logic [15:0] ADDR_GLASS_RATE_LO = 16'h0027;
	localparam logic [15:0] ADDR_AMB_MULT      = 16'h002c;
	localparam logic [15:0] ADDR_CHECK_EN      = 16'h002d;
	localparam logic [15:0] ADDR_RECAL_CTRL    = 16'h002e;
	localparam logic [15:0] ADDR_RECAL_REPEAT  = 16'h0031;

	// ==========================================================
	// Reset values
	localparam logic [15:0] RST_GLASS_RATE    = 16'h0000;
	localparam logic [7:0]  RST_AMB_MULT      = 8'ha0;
	localparam logic [7:0]  RST_CHECK_EN      = 8'h11;
	localparam logic [7:0]  RST_RECAL_REPEAT  = 8'h00;

	// ==========================================================
	// Field positions
	localparam int          BIT_SNR_EN        = 4;
	localparam int          BIT_GLASS_EN      = 1;
	localparam int          BIT_EARLY_EN      = 0;
	localparam logic [7:0]  CHECK_EN_MASK     = 8'h13;
	localparam int          BIT_RECAL_STATUS  = 1;
	localparam int          BIT_RECAL_MANUAL  = 0;
	localparam int          MULT_FRAC_BITS    = 4;

	// ==========================================================
	// Serial link
	// Device address: arbitrary value
	localparam logic [6:0]  DEV_ADDR          = 7'h3a;

	// Link slave states, Gray along the usual path
	typedef enum logic [2:0] {
		LS_IDLE = 3'b000,
		LS_RECV = 3'b001,
		LS_ACK  = 3'b011,
		LS_SEND = 3'b010,
		LS_RACK = 3'b110
	} rcbr_link_e;

	// Recalibration engine states
	typedef enum logic [1:0] {
		RS_IDLE   = 2'b00,
		RS_MANUAL = 2'b01,
		RS_AUTO   = 2'b11
	} rcbr_recal_e;

endpackage

// ==== src/rcbr_reg_if.sv ====
// Register access carrier between link slave and register bank
`timescale 1ns/1ns
`default_nettype none
interface rcbr_reg_if;
	logic [15:0] rd_addr;
	logic [7:0]  rd_data;
	logic        wr_en;
	logic [15:0] wr_addr;
	logic [7:0]  wr_data;

	modport link (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport bank (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// ==== src/rcbr_link_slave.sv ====
// Two-wire serial slave with 16-bit register index and auto-increment
`timescale 1ns/1ns
`default_nettype none
module rcbr_link_slave
	import rcbr_pkg::*;
(
	input  wire logic  i_sys_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	output logic       o_sda_out,
	output logic       o_sda_oe,
	rcbr_reg_if.link   regs
);

	logic [1:0]  scl_sync, sda_sync;
	logic        scl_d, sda_d;
	rcbr_link_e  state, next_state;
	logic [2:0]  bitcnt, next_bitcnt;
	logic [1:0]  phase, next_phase;
	logic        full, next_full;
	logic        rw, next_rw;
	logic [7:0]  shift, next_shift;
	logic [15:0] idx, next_idx;
	logic        sda_oe, next_sda_oe;
	logic        wr_en, next_wr_en;
	logic [15:0] wr_addr, next_wr_addr;
	logic [7:0]  wr_data, next_wr_data;
	logic        scl_rise, scl_fall, start_cond, stop_cond;

	assign scl_rise   = scl_sync[1] & ~scl_d;
	assign scl_fall   = ~scl_sync[1] & scl_d;
	assign start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign stop_cond  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	assign regs.rd_addr = idx;
	assign regs.wr_en   = wr_en;
	assign regs.wr_addr = wr_addr;
	assign regs.wr_data = wr_data;
	assign o_sda_oe     = sda_oe;
	assign o_sda_out    = 1'b0;

	// ==========================================================
	// Next state
	always_comb begin
		next_state   = state;
		next_bitcnt  = bitcnt;
		next_phase   = phase;
		next_full    = full;
		next_rw      = rw;
		next_shift   = shift;
		next_idx     = idx;
		next_sda_oe  = sda_oe;
		next_wr_en   = 1'b0;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		if (start_cond) begin
			next_state  = LS_RECV;
			next_bitcnt = 3'h0;
			next_phase  = 2'h0;
			next_full   = 1'b0;
			next_sda_oe = 1'b0;
		end else if (stop_cond) begin
			next_state  = LS_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				LS_RECV: begin
					if (scl_rise) begin
						next_shift  = {shift[6:0], sda_sync[1]};
						next_bitcnt = bitcnt + 3'h1;
						next_full   = (bitcnt == 3'h7);
					end else if (scl_fall && full) begin
						next_full   = 1'b0;
						next_state  = LS_ACK;
						next_sda_oe = 1'b1;
						if (phase != 2'h3) begin
							next_phase = phase + 2'h1;
						end
						if (phase == 2'h0) begin
							next_rw = shift[0];
							if (shift[7:1] != DEV_ADDR) begin
								next_state  = LS_IDLE;
								next_sda_oe = 1'b0;
							end
						end else if (phase == 2'h1) begin
							next_idx[15:8] = shift;
						end else if (phase == 2'h2) begin
							next_idx[7:0] = shift;
						end else begin
							next_wr_en   = 1'b1;
							next_wr_addr = idx;
							next_wr_data = shift;
							next_idx     = idx + 16'h0001;
						end
					end
				end
				LS_ACK: begin
					if (scl_fall) begin
						next_bitcnt = 3'h0;
						if (rw) begin
							next_state  = LS_SEND;
							next_shift  = regs.rd_data;
							next_idx    = idx + 16'h0001;
							next_sda_oe = ~regs.rd_data[7];
						end else begin
							next_state  = LS_RECV;
							next_sda_oe = 1'b0;
						end
					end
				end
				LS_SEND: begin
					if (scl_fall) begin
						if (bitcnt == 3'h7) begin
							next_state  = LS_RACK;
							next_sda_oe = 1'b0;
						end else begin
							next_shift  = {shift[6:0], 1'b0};
							next_sda_oe = ~shift[6];
							next_bitcnt = bitcnt + 3'h1;
						end
					end
				end
				LS_RACK: begin
					if (scl_rise && sda_sync[1]) begin
						next_state = LS_IDLE;
					end else if (scl_fall) begin
						next_state  = LS_SEND;
						next_bitcnt = 3'h0;
						next_shift  = regs.rd_data;
						next_idx    = idx + 16'h0001;
						next_sda_oe = ~regs.rd_data[7];
					end
				end
				default: begin
					next_state = LS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
			state    <= LS_IDLE;
			bitcnt   <= 3'h0;
			phase    <= 2'h0;
			full     <= 1'b0;
			rw       <= 1'b0;
			shift    <= 8'h00;
			idx      <= 16'h0000;
			sda_oe   <= 1'b0;
			wr_en    <= 1'b0;
			wr_addr  <= 16'h0000;
			wr_data  <= 8'h00;
		end else begin
			scl_sync <= {scl_sync[0], i_scl};
			sda_sync <= {sda_sync[0], i_sda};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
			state    <= next_state;
			bitcnt   <= next_bitcnt;
			phase    <= next_phase;
			full     <= next_full;
			rw       <= next_rw;
			shift    <= next_shift;
			idx      <= next_idx;
			sda_oe   <= next_sda_oe;
			wr_en    <= next_wr_en;
			wr_addr  <= next_wr_addr;
			wr_data  <= next_wr_data;
		end
	end

endmodule
`default_nettype wire

// ==== src/rcbr_top.sv ====
// Range check and bias recalibration register bank with its check and recal logic
// Overview of operation
// - Hold 16-bit 9.7 cover-glass rate threshold.
// - Abort when ambient exceeds signal times multiplier.
// - Multiplier is unsigned 4.4, reset 0xa0.
// - Boot load overwrites multiplier and enables.
// - Enable bits 4,1,0; upper bits read-only.
// - Status bit high during automatic calibration.
// - Host-set bit 0 runs recal, self-clears.
// - Auto recal every N measurements, 0 off.
`timescale 1ns/1ns
`default_nettype none
module rcbr_top
	import rcbr_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	input  wire logic        i_nvm_load,
	input  wire logic [7:0]  i_nvm_amb_mult,
	input  wire logic [7:0]  i_nvm_check_en,
	input  wire logic        i_check_valid,
	input  wire logic [15:0] i_ambient_count,
	input  wire logic [15:0] i_signal_count,
	input  wire logic [15:0] i_signal_rate,
	output logic             o_check_done,
	output logic             o_ambient_abort,
	output logic             o_cover_glass_reject,
	output logic             o_snr_check_on,
	output logic             o_glass_check_on,
	output logic             o_early_conv_on,
	input  wire logic        i_meas_done,
	output logic             o_bias_cal_start,
	output logic             o_bias_cal_active,
	input  wire logic        i_bias_cal_done
);

	rcbr_reg_if regs ();

	logic        sda_out_w, sda_oe_w;
	logic [15:0] glass_rate, next_glass_rate;
	logic [7:0]  amb_mult, next_amb_mult;
	logic [7:0]  check_en, next_check_en;
	logic [7:0]  recal_repeat, next_recal_repeat;
	logic        recal_manual, next_recal_manual;
	logic        recal_status, next_recal_status;
	rcbr_recal_e rstate, next_rstate;
	logic [7:0]  meas_cnt, next_meas_cnt;
	logic        auto_pend, next_auto_pend;
	logic        cal_start, next_cal_start;
	logic        chk_done, next_chk_done;
	logic        amb_abort, next_amb_abort;
	logic        glass_rej, next_glass_rej;
	logic        sda_oe_q, sda_out_q;

	// ==========================================================
	// Link slave
	rcbr_link_slave u_link (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_scl     (i_scl),
		.i_sda     (i_sda),
		.o_sda_out (sda_out_w),
		.o_sda_oe  (sda_oe_w),
		.regs      (regs.link)
	);

	// ==========================================================
	// Read decode
	function automatic logic [7:0] read_reg(input logic [15:0] a, input logic [15:0] gr,
		input logic [7:0] am, input logic [7:0] ce, input logic [7:0] rr,
		input logic rs, input logic rm);
		logic [7:0] d;
		d = 8'h00;
		if (a == ADDR_GLASS_RATE_HI) begin
			d = gr[15:8];
		end else if (a == ADDR_GLASS_RATE_LO) begin
			d = gr[7:0];
		end else if (a == ADDR_AMB_MULT) begin
			d = am;
		end else if (a == ADDR_CHECK_EN) begin
			d = ce & CHECK_EN_MASK;
		end else if (a == ADDR_RECAL_CTRL) begin
			d[BIT_RECAL_STATUS] = rs;
			d[BIT_RECAL_MANUAL] = rm;
		end else if (a == ADDR_RECAL_REPEAT) begin
			d = rr;
		end
		return d;
	endfunction

	assign regs.rd_data = read_reg(regs.rd_addr, glass_rate, amb_mult, check_en,
		recal_repeat, recal_status, recal_manual);

	// ==========================================================
	// Register writes and boot load
	always_comb begin
		next_glass_rate   = glass_rate;
		next_amb_mult     = amb_mult;
		next_check_en     = check_en;
		next_recal_repeat = recal_repeat;
		next_recal_manual = recal_manual;
		if (regs.wr_en) begin
			if (regs.wr_addr == ADDR_GLASS_RATE_HI) begin
				next_glass_rate[15:8] = regs.wr_data;
			end else if (regs.wr_addr == ADDR_GLASS_RATE_LO) begin
				next_glass_rate[7:0] = regs.wr_data;
			end else if (regs.wr_addr == ADDR_AMB_MULT) begin
				next_amb_mult = regs.wr_data;
			end else if (regs.wr_addr == ADDR_CHECK_EN) begin
				next_check_en = regs.wr_data & CHECK_EN_MASK;
			end else if (regs.wr_addr == ADDR_RECAL_CTRL) begin
				if (regs.wr_data[BIT_RECAL_MANUAL]) begin
					next_recal_manual = 1'b1;
				end
			end else if (regs.wr_addr == ADDR_RECAL_REPEAT) begin
				next_recal_repeat = regs.wr_data;
			end
		end
		if (i_nvm_load) begin
			next_amb_mult = i_nvm_amb_mult;
			next_check_en = i_nvm_check_en & CHECK_EN_MASK;
		end
		// Completion clears the trigger unless a new request lands now
		if (rstate == RS_MANUAL && i_bias_cal_done &&
			!(regs.wr_en && regs.wr_addr == ADDR_RECAL_CTRL &&
			regs.wr_data[BIT_RECAL_MANUAL])) begin
			next_recal_manual = 1'b0;
		end
	end

	// ==========================================================
	// Measurement counter and recalibration engine
	always_comb begin
		next_rstate       = rstate;
		next_meas_cnt     = meas_cnt;
		next_auto_pend    = auto_pend;
		next_cal_start    = 1'b0;
		next_recal_status = recal_status;
		case (rstate)
			RS_IDLE: begin
				if (recal_manual) begin
					next_rstate    = RS_MANUAL;
					next_cal_start = 1'b1;
				end else if (auto_pend) begin
					next_rstate       = RS_AUTO;
					next_cal_start    = 1'b1;
					next_auto_pend    = 1'b0;
					next_recal_status = 1'b1;
				end
			end
			RS_MANUAL: begin
				if (i_bias_cal_done) begin
					next_rstate = RS_IDLE;
				end
			end
			RS_AUTO: begin
				if (i_bias_cal_done) begin
					next_rstate       = RS_IDLE;
					next_recal_status = 1'b0;
				end
			end
			default: begin
				next_rstate = RS_IDLE;
			end
		endcase
		// Counted after the engine so a hit in the take cycle stays pending
		if (recal_repeat == 8'h00) begin
			next_meas_cnt  = 8'h00;
			next_auto_pend = 1'b0;
		end else if (i_meas_done) begin
			if (meas_cnt + 8'h01 >= recal_repeat) begin
				next_meas_cnt  = 8'h00;
				next_auto_pend = 1'b1;
			end else begin
				next_meas_cnt = meas_cnt + 8'h01;
			end
		end
	end

	// ==========================================================
	// Validity checks
	always_comb begin
		next_chk_done  = i_check_valid;
		next_amb_abort = amb_abort;
		next_glass_rej = glass_rej;
		if (i_check_valid) begin
			// Ambient scaled by 16 matches the 4.4 multiplier
			next_amb_abort = check_en[BIT_SNR_EN] &&
				({4'h0, i_ambient_count, 4'h0} > (24'(i_signal_count) * 24'(amb_mult)));
			next_glass_rej = check_en[BIT_GLASS_EN] &&
				(i_signal_rate < glass_rate);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			glass_rate   <= RST_GLASS_RATE;
			amb_mult     <= RST_AMB_MULT;
			check_en     <= RST_CHECK_EN;
			recal_repeat <= RST_RECAL_REPEAT;
			recal_manual <= 1'b0;
			recal_status <= 1'b0;
			rstate       <= RS_IDLE;
			meas_cnt     <= 8'h00;
			auto_pend    <= 1'b0;
			cal_start    <= 1'b0;
			chk_done     <= 1'b0;
			amb_abort    <= 1'b0;
			glass_rej    <= 1'b0;
			sda_oe_q     <= 1'b0;
			sda_out_q    <= 1'b0;
		end else begin
			glass_rate   <= next_glass_rate;
			amb_mult     <= next_amb_mult;
			check_en     <= next_check_en;
			recal_repeat <= next_recal_repeat;
			recal_manual <= next_recal_manual;
			recal_status <= next_recal_status;
			rstate       <= next_rstate;
			meas_cnt     <= next_meas_cnt;
			auto_pend    <= next_auto_pend;
			cal_start    <= next_cal_start;
			chk_done     <= next_chk_done;
			amb_abort    <= next_amb_abort;
			glass_rej    <= next_glass_rej;
			sda_oe_q     <= sda_oe_w;
			sda_out_q    <= sda_out_w;
		end
	end

	assign o_sda_out            = sda_out_q;
	assign o_sda_oe             = sda_oe_q;
	assign o_check_done         = chk_done;
	assign o_ambient_abort      = amb_abort;
	assign o_cover_glass_reject = glass_rej;
	assign o_snr_check_on       = check_en[BIT_SNR_EN];
	assign o_glass_check_on     = check_en[BIT_GLASS_EN];
	assign o_early_conv_on      = check_en[BIT_EARLY_EN];
	assign o_bias_cal_start     = cal_start;
	assign o_bias_cal_active    = rstate[0];

endmodule
`default_nettype wire

// ==== tb/rcbr_top_assertions.sv ====
// Concurrent checks on the register bank top ports
`timescale 1ns/1ns
`default_nettype none
module rcbr_top_assertions (
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	input wire logic        i_check_valid,
	input wire logic [15:0] i_ambient_count,
	input wire logic        i_nvm_load,
	input wire logic [7:0]  i_nvm_check_en,
	input wire logic        i_bias_cal_done,
	input wire logic        o_check_done,
	input wire logic        o_ambient_abort,
	input wire logic        o_cover_glass_reject,
	input wire logic        o_snr_check_on,
	input wire logic        o_glass_check_on,
	input wire logic        o_early_conv_on,
	input wire logic        o_bias_cal_start,
	input wire logic        o_bias_cal_active
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	logic [2:0] en_sel;
	assign en_sel = {i_nvm_check_en[4], i_nvm_check_en[1], i_nvm_check_en[0]};

	// ==========================================================
	// Check strobe
	property p_done; i_check_valid |=> o_check_done; endproperty
	a_done: assert property (p_done) else $error("check done missing");
	property p_no_done; !i_check_valid |=> !o_check_done; endproperty
	a_no_done: assert property (p_no_done) else $error("spurious check done");
	property p_flag_hold;
		!o_check_done |-> $stable(o_ambient_abort) && $stable(o_cover_glass_reject);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flags moved");
	property p_snr_off; i_check_valid && !o_snr_check_on |=> !o_ambient_abort; endproperty
	a_snr_off: assert property (p_snr_off) else $error("abort while off");
	property p_amb_zero; i_check_valid && i_ambient_count == 16'h0000 |=> !o_ambient_abort;
	endproperty
	a_amb_zero: assert property (p_amb_zero) else $error("abort on zero ambient");
	property p_glass_off; i_check_valid && !o_glass_check_on |=> !o_cover_glass_reject;
	endproperty
	a_glass_off: assert property (p_glass_off) else $error("reject while off");

	// ==========================================================
	// Boot load and recalibration
	property p_nvm;
		i_nvm_load |=> {o_snr_check_on, o_glass_check_on, o_early_conv_on} == $past(en_sel);
	endproperty
	a_nvm: assert property (p_nvm) else $error("boot load not applied");
	property p_start; o_bias_cal_start |-> o_bias_cal_active ##1 !o_bias_cal_start; endproperty
	a_start: assert property (p_start) else $error("start pulse bad");
	property p_rise; $rose(o_bias_cal_active) |-> o_bias_cal_start; endproperty
	a_rise: assert property (p_rise) else $error("active without start");
	property p_busy; o_bias_cal_active && !i_bias_cal_done |=> o_bias_cal_active; endproperty
	a_busy: assert property (p_busy) else $error("active dropped early");
	property p_end; o_bias_cal_active && i_bias_cal_done |=> !o_bias_cal_active; endproperty
	a_end: assert property (p_end) else $error("active not cleared");
endmodule
`default_nettype wire

// ==== tb/rcbr_host_model.sv ====
// Serial link host that reads and writes the register bank
`timescale 1ns/1ns
`default_nettype none
module rcbr_host_model
	import rcbr_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic hp;
		repeat (6) @(negedge i_sys_clk);
	endtask
	task automatic start;
		o_sda_oe = 1'b0;
		hp;
		o_scl = 1'b1;
		hp;
		o_sda_oe = 1'b1;
		hp;
		o_scl = 1'b0;
	endtask
	task automatic stop;
		hp;
		o_sda_oe = 1'b1;
		hp;
		o_scl = 1'b1;
		hp;
		o_sda_oe = 1'b0;
		hp;
	endtask
	task automatic bit_io(input logic b, output logic r);
		hp;
		o_sda_oe = !b;
		hp;
		o_scl = 1'b1;
		hp;
		r = i_sda;
		o_scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ai, ak);
	endtask
	// Index high, index low, then n data bytes high first
	task automatic wr(input logic [6:0] a, input logic [15:0] idx, input logic [15:0] d,
		input int n, output logic nak);
		logic [7:0] q;
		logic       k;
		start;
		xfer({a, 1'b0}, 1'b1, q, nak);
		xfer(idx[15:8], 1'b1, q, k);
		xfer(idx[7:0], 1'b1, q, k);
		for (int i = n - 1; i >= 0; i--) xfer(d[8*i+:8], 1'b1, q, k);
		stop;
	endtask
	// Last byte answered with a refusal so the device lets go
	task automatic rd(input logic [15:0] idx, input int n, output logic [15:0] q);
		logic [7:0] b;
		logic       k;
		start;
		xfer({DEV_ADDR, 1'b0}, 1'b1, b, k);
		xfer(idx[15:8], 1'b1, b, k);
		xfer(idx[7:0], 1'b1, b, k);
		start;
		xfer({DEV_ADDR, 1'b1}, 1'b1, b, k);
		q = 16'h0000;
		for (int i = 0; i < n; i++) begin
			xfer(8'hff, i == n - 1, b, k);
			q = {q[7:0], b};
		end
		stop;
	endtask
endmodule
`default_nettype wire

// ==== tb/rcbr_top_tb.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module rcbr_top_tb;
	import rcbr_pkg::*;
	logic clk = 0, rst_n = 0, nvm_load = 0, chk_v = 0, meas = 0, cal_done = 0, nak, seen;
	logic [7:0]  nvm_mult = 8'h00, nvm_en = 8'h00;
	logic [15:0] amb = 16'h0000, sig = 16'h0000, rate = 16'h0000, q;
	wire logic   sda, scl, host_oe, sda_out, sda_oe, done, abort, reject;
	wire logic   snr_on, glass_on, early_on, cal_start, cal_active;
	int          n_fail = 0, cmp_count = 0;

	always #20 clk = ~clk;
	assign sda = ((sda_oe && !sda_out) || host_oe) ? 1'b0 : 1'b1;
	always @(posedge clk) if (cal_start) seen <= 1'b1;

	rcbr_host_model host (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
	rcbr_top dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_nvm_load(nvm_load),
		.i_nvm_amb_mult(nvm_mult), .i_nvm_check_en(nvm_en), .i_check_valid(chk_v),
		.i_ambient_count(amb), .i_signal_count(sig), .i_signal_rate(rate),
		.o_check_done(done), .o_ambient_abort(abort), .o_cover_glass_reject(reject),
		.o_snr_check_on(snr_on), .o_glass_check_on(glass_on), .o_early_conv_on(early_on),
		.i_meas_done(meas), .o_bias_cal_start(cal_start), .o_bias_cal_active(cal_active),
		.i_bias_cal_done(cal_done));

	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [15:0] idx, input int n, input logic [15:0] exp);
		host.rd(idx, n, q);
		chk(q, exp);
	endtask
	task automatic wr(input logic [15:0] idx, input logic [15:0] d, input int n);
		host.wr(DEV_ADDR, idx, d, n, nak);
	endtask
	task automatic pulse_meas;
		@(negedge clk) meas = 1'b1;
		@(negedge clk) meas = 1'b0;
	endtask
	task automatic pulse_done;
		@(negedge clk) cal_done = 1'b1;
		@(negedge clk) cal_done = 1'b0;
	endtask
	task automatic wait_start;
		for (int i = 0; i < 400; i++) begin
			@(negedge clk);
			if (seen === 1'b1) return;
		end
		n_fail++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, seen, 1'b1);
		complete_run;
	endtask
	task automatic check(input logic [15:0] a, s, r, input logic [2:0] exp);
		@(negedge clk) {amb, sig, rate, chk_v} = {a, s, r, 1'b1};
		@(negedge clk) chk_v = 1'b0;
		chk({done, abort, reject}, exp);
	endtask
	task automatic nvm(input logic [7:0] m, e, input logic [2:0] exp);
		@(negedge clk) {nvm_mult, nvm_en, nvm_load} = {m, e, 1'b1};
		@(negedge clk) nvm_load = 1'b0;
		chk({snr_on, glass_on, early_on}, exp);
	endtask

	task automatic t_reset;
		chk({snr_on, glass_on, early_on}, 3'b101);
		rchk(ADDR_GLASS_RATE_HI, 2, RST_GLASS_RATE);
		rchk(ADDR_AMB_MULT, 1, 16'h00a0);
		rchk(ADDR_CHECK_EN, 1, 16'h0011);
		rchk(ADDR_RECAL_CTRL, 1, 16'h0000);
		rchk(ADDR_RECAL_REPEAT, 1, 16'h0000);
		$display("reset values done");
	endtask
	task automatic t_regs;
		wr(ADDR_GLASS_RATE_HI, 16'h1234, 2);
		rchk(ADDR_GLASS_RATE_HI, 2, 16'h1234);
		wr(ADDR_CHECK_EN, 16'h00ff, 1);
		rchk(ADDR_CHECK_EN, 1, 16'h0013);
		chk({snr_on, glass_on, early_on}, 3'b111);
		host.wr(7'h3b, ADDR_AMB_MULT, 16'h0055, 1, nak);
		chk(nak, 1'b1);
		rchk(ADDR_AMB_MULT, 1, 16'h00a0);
		wr(16'h0040, 16'h0077, 1);
		rchk(16'h0040, 1, 16'h0000);
		$display("register access done");
	endtask
	task automatic t_nvm;
		nvm(8'h30, 8'hec, 3'b000);
		nvm(8'h20, 8'hff, 3'b111);
		rchk(ADDR_AMB_MULT, 1, 16'h0020);
		rchk(ADDR_CHECK_EN, 1, 16'h0013);
		$display("boot load done");
	endtask
	task automatic t_checks;
		check(16'd201, 16'd100, 16'h1234, 3'b110);
		check(16'd200, 16'd100, 16'h1233, 3'b101);
		check(16'd0, 16'd100, 16'h2000, 3'b100);
		wr(ADDR_CHECK_EN, 16'h0000, 1);
		check(16'd201, 16'd100, 16'h1233, 3'b100);
		$display("validity checks done");
	endtask
	task automatic t_manual;
		seen = 1'b0;
		wr(ADDR_RECAL_CTRL, 16'h0001, 1);
		wait_start;
		rchk(ADDR_RECAL_CTRL, 1, 16'h0001);
		chk(cal_active, 1'b1);
		pulse_done;
		chk(cal_active, 1'b0);
		rchk(ADDR_RECAL_CTRL, 1, 16'h0000);
		$display("manual recal done");
	endtask
	task automatic t_auto;
		wr(ADDR_RECAL_REPEAT, 16'h0003, 1);
		seen = 1'b0;
		pulse_meas;
		pulse_meas;
		repeat (6) @(negedge clk);
		chk(seen, 1'b0);
		pulse_meas;
		wait_start;
		rchk(ADDR_RECAL_CTRL, 1, 16'h0002);
		pulse_done;
		chk(cal_active, 1'b0);
		rchk(ADDR_RECAL_CTRL, 1, 16'h0000);
		$display("auto recal done");
	endtask
	task automatic t_repeat;
		wr(ADDR_RECAL_REPEAT, 16'h0002, 1);
		seen = 1'b0;
		// Three measurements back to back: one hit, then the third only counted in the take cycle
		@(negedge clk) meas = 1'b1;
		repeat (3) @(negedge clk);
		meas = 1'b0;
		wait_start;
		pulse_done;
		seen = 1'b0;
		repeat (8) @(negedge clk);
		chk(seen, 1'b0);
		wr(ADDR_RECAL_REPEAT, 16'h0000, 1);
		pulse_meas;
		pulse_meas;
		pulse_meas;
		repeat (8) @(negedge clk);
		chk(seen, 1'b0);
		rchk(ADDR_RECAL_CTRL, 1, 16'h0000);
		$display("repeat rate done");
	endtask

	initial begin
		seen = 1'b0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset;
		t_regs;
		t_nvm;
		t_checks;
		t_manual;
		t_auto;
		t_repeat;
		complete_run;
	end
endmodule
bind rcbr_top rcbr_top_assertions u_chk (.*);
`default_nettype wire
